/* mrbl_pkg.sv */
// Constants and carrier types for the low metering register bank.
// Assumes the bank runs on one device clock and that all users
// refer to these names through mrbl_pkg:: with no import.
package mrbl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register addresses, as carried in the five low bits of a command.
  localparam logic [4:0] ADDR_WAVEFORM  = 5'h01; // Sampled waveform.
  localparam logic [4:0] ADDR_AE_ACCUM  = 5'h02; // Active energy.
  localparam logic [4:0] ADDR_AE_RCLR   = 5'h03; // Active, read-clear.
  localparam logic [4:0] ADDR_AE_LINE   = 5'h04; // Active, line cycle.
  localparam logic [4:0] ADDR_VA_ACCUM  = 5'h05; // Apparent energy.
  localparam logic [4:0] ADDR_VA_RCLR   = 5'h06; // Apparent, read-clear.
  localparam logic [4:0] ADDR_VA_LINE   = 5'h07; // Apparent, line cycle.
  localparam logic [4:0] ADDR_VAR_LINE  = 5'h08; // Reactive, line cycle.
  localparam logic [4:0] ADDR_MODE      = 5'h09; // Operating mode.
  localparam logic [4:0] ADDR_IRQ_MASK  = 5'h0A; // Interrupt enables.
  localparam logic [4:0] ADDR_FLAGS     = 5'h0B; // Interrupt flags.
  localparam logic [4:0] ADDR_FLAGS_RC  = 5'h0C; // Flags, read-clear.
  localparam logic [4:0] ADDR_CUR_OFS   = 5'h0D; // Current offset.
  localparam logic [4:0] ADDR_VOLT_OFS  = 5'h0E; // Voltage offset.
  localparam logic [4:0] ADDR_GAIN      = 5'h0F; // Amplifier gain.

  ////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [15:0] MODE_RST      = 16'h000C;
  localparam logic [15:0] IRQ_MASK_RST  = 16'h0040;
  localparam logic [15:0] FLAGS_RST     = 16'h0000;
  localparam logic [23:0] ENERGY_RST    = 24'h000000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int          CMD_WRITE_BIT = 7;     // One means write.
  localparam int          WSRC_HI       = 14;    // Waveform source, high.
  localparam int          WSRC_LO       = 13;    // Waveform source, low.
  localparam logic [1:0]  WSRC_CH1      = 2'h2;  // Current channel.
  localparam logic [1:0]  WSRC_CH2      = 2'h3;  // Voltage channel.
  localparam int          OFS_MSB       = 5;     // Offset value 5..0.
  localparam int          INTEG_BIT     = 7;     // Integrator enable.

  ////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef struct packed {
    logic [23:0] active;   // Instantaneous active power.
    logic [23:0] apparent; // Instantaneous apparent power.
    logic [23:0] reactive; // Instantaneous reactive power.
  } mrbl_power_s;

  typedef struct packed {
    logic [23:0] ch1;      // Current channel sample.
    logic [15:0] ch2;      // Voltage channel sample.
  } mrbl_wave_s;

  // Serial engine states, one-hot.
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_RD  = 3'b010,
    ST_WR  = 3'b100
  } mrbl_state_e;

endpackage : mrbl_pkg

/* mrbl_bank.sv */
// Low register bank of an energy meter with its serial command port.
// Assumes the serial pins come from a host in another clock domain and
// that power, waveform, half-cycle and event inputs are on clk.
//
// What this block does
// - Read-only waveform register from selected source
// - Mode bits 14:13 choose waveform source; length fixed at 24 bits
// - Active power integrates into read-only accumulator
// - Address 03h mirrors active energy, clears after read
// - Apparent power integrates into read-only accumulator
// - Address 06h mirrors apparent energy, clears after read
// - Line active energy over programmed half cycles
// - Line apparent, reactive energy over half cycles
// - Mode register resets 000Ch, writable, always readable
// - Disabled interrupt still flags, keeps request inactive
// - Read-only status holds one flag per source
// - Reading 0Ch returns flags then clears all
// - Current offset bits 5:0 used, bit 6 ignored
// - Current offset MSB enables integrator, resets zero
// - Voltage offset bits 5:0 used, 7:6 ignored
// - Writable gain register selects both channel gains
// - Command byte: top bit write, low five address
// - Data MSB byte first, right-justified, up to three
// - Read snapshots whole register into serial port
`timescale 1ns/1ns
module mrbl_bank (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 sclk,
  input  wire logic                 din,
  input  wire logic                 cs_n,
  output logic                      dout_o,
  output logic                      dout_oe,
  output logic                      irq_n_o,
  output logic                      irq_n_oe,
  input  wire mrbl_pkg::mrbl_power_s power,
  input  wire logic                 power_valid,
  input  wire mrbl_pkg::mrbl_wave_s wave,
  input  wire logic                 wave_valid,
  input  wire logic                 half_cycle,
  input  wire logic [14:0]          half_cycle_count_setting,
  input  wire logic [15:0]          events,
  output logic [15:0]               mode,
  output logic                      integrator_en,
  output logic [5:0]                current_offset,
  output logic [5:0]                voltage_offset,
  output logic [7:0]                gain
);

  ////////////////////////////////////////////////////////////////////////
  // Register width in bits; used by the command decode for reads and
  // for the byte lane of writes.
  function automatic logic [4:0] reg_bits(input logic [4:0] a);
    if (a >= mrbl_pkg::ADDR_WAVEFORM && a <= mrbl_pkg::ADDR_VAR_LINE) begin
      reg_bits = 5'h18;
    end else if (a >= mrbl_pkg::ADDR_MODE &&
                 a <= mrbl_pkg::ADDR_FLAGS_RC) begin
      reg_bits = 5'h10;
    end else begin
      reg_bits = 5'h08;
    end
  endfunction : reg_bits

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Stage 0 feeds only stage 1; edges are found
  // between stages 1 and 2 so a metastable value never reaches logic.
  logic [2:0] sclk_q;   // Serial clock pipeline.
  logic [1:0] din_q;    // Serial data pipeline.
  logic [2:0] cs_q;     // Chip select pipeline.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 3'h7; // Idle high: no false edge after reset.
      din_q  <= 2'h0;
      cs_q   <= 3'h7;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      din_q  <= {din_q[0], din};
      cs_q   <= {cs_q[1:0], cs_n};
    end
  end

  logic sclk_rise; // Rising edge seen on the serial clock.
  logic sclk_fall; // Falling edge seen on the serial clock.
  logic cs_idle;   // Chip select released.
  logic din_s;     // Synchronised serial data.
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_idle   = cs_q[1];
  assign din_s     = din_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic [23:0] wave_r;                 // Sampled waveform.
  logic [23:0] ae_r, ae_rc_r, va_r, va_rc_r;
  logic [23:0] line_acc_r [3];         // Running line-cycle sums.
  logic [23:0] line_r [3];             // Latched line-cycle results.
  logic [14:0] hc_cnt_r;               // Half cycles seen so far.
  logic [15:0] mode_r, mask_r, flags_r;
  logic [7:0]  cur_ofs_r, volt_ofs_r, gain_r;

  // Serial engine state.
  mrbl_pkg::mrbl_state_e state_r;
  logic [4:0]  bit_cnt_r;  // Bits moved in the current phase.
  logic [4:0]  nbits_r;    // Bits in the addressed register.
  logic [4:0]  addr_r;     // Addressed register.
  logic [23:0] shift_r;    // Serial shift register.
  logic        wr_en_r;    // One-cycle pulse: a data byte arrived.
  logic [1:0]  wr_lane_r;  // Byte lane of that byte.
  logic [7:0]  wr_byte_r;  // The byte itself.
  logic        rd_done_r;  // One-cycle pulse: a read completed.

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer, looked at only when a read command lands.
  logic [4:0]  cmd_addr;  // Address in the byte now completing.
  logic [23:0] rd_mux;    // Value of that register.
  assign cmd_addr = {shift_r[3:0], din_s};

  always_comb begin
    unique case (cmd_addr)
      mrbl_pkg::ADDR_WAVEFORM: rd_mux = wave_r;
      mrbl_pkg::ADDR_AE_ACCUM: rd_mux = ae_r;
      mrbl_pkg::ADDR_AE_RCLR:  rd_mux = ae_rc_r;
      mrbl_pkg::ADDR_AE_LINE:  rd_mux = line_r[0];
      mrbl_pkg::ADDR_VA_ACCUM: rd_mux = va_r;
      mrbl_pkg::ADDR_VA_RCLR:  rd_mux = va_rc_r;
      mrbl_pkg::ADDR_VA_LINE:  rd_mux = line_r[1];
      mrbl_pkg::ADDR_VAR_LINE: rd_mux = line_r[2];
      mrbl_pkg::ADDR_MODE:     rd_mux = {8'h00, mode_r};
      mrbl_pkg::ADDR_IRQ_MASK: rd_mux = {8'h00, mask_r};
      mrbl_pkg::ADDR_FLAGS,
      mrbl_pkg::ADDR_FLAGS_RC: rd_mux = {8'h00, flags_r};
      mrbl_pkg::ADDR_CUR_OFS:  rd_mux = {16'h0000, cur_ofs_r};
      mrbl_pkg::ADDR_VOLT_OFS: rd_mux = {16'h0000, volt_ofs_r};
      mrbl_pkg::ADDR_GAIN:     rd_mux = {16'h0000, gain_r};
      default:                 rd_mux = 24'h000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial engine. Data enters on falling and leaves on rising serial
  // clock edges; chip select high aborts and returns to command mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= mrbl_pkg::ST_CMD;
      bit_cnt_r <= 5'h00;
      nbits_r   <= 5'h08;
      addr_r    <= 5'h00;
      shift_r   <= 24'h000000;
      dout_o    <= 1'b0;
      dout_oe   <= 1'b0;
      wr_en_r   <= 1'b0;
      wr_lane_r <= 2'h0;
      wr_byte_r <= 8'h00;
      rd_done_r <= 1'b0;
    end else begin
      wr_en_r   <= 1'b0;
      rd_done_r <= 1'b0;
      if (cs_idle) begin
        // An aborted byte is never handed to the registers.
        state_r   <= mrbl_pkg::ST_CMD;
        bit_cnt_r <= 5'h00;
        dout_oe   <= 1'b0;
      end else begin
        unique case (state_r)
          mrbl_pkg::ST_CMD: begin
            if (sclk_fall) begin
              shift_r   <= {shift_r[22:0], din_s};
              bit_cnt_r <= bit_cnt_r + 5'h01;
              if (bit_cnt_r == 5'h07) begin
                addr_r    <= cmd_addr;
                nbits_r   <= reg_bits(cmd_addr);
                bit_cnt_r <= 5'h00;
                if (shift_r[mrbl_pkg::CMD_WRITE_BIT - 1]) begin
                  state_r <= mrbl_pkg::ST_WR;
                end else begin
                  // Whole register caught at once, MSB aligned.
                  shift_r <= rd_mux << (5'h18 - reg_bits(cmd_addr));
                  state_r <= mrbl_pkg::ST_RD;
                end
              end
            end
          end
          mrbl_pkg::ST_RD: begin
            if (sclk_rise && bit_cnt_r != nbits_r) begin
              dout_oe   <= 1'b1;
              dout_o    <= shift_r[23];
              shift_r   <= {shift_r[22:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 5'h01;
            end else if (sclk_fall && bit_cnt_r == nbits_r) begin
              // Last bit has been sampled by the host.
              dout_oe   <= 1'b0;
              rd_done_r <= 1'b1;
              bit_cnt_r <= 5'h00;
              state_r   <= mrbl_pkg::ST_CMD;
            end
          end
          mrbl_pkg::ST_WR: begin
            if (sclk_fall) begin
              shift_r   <= {shift_r[22:0], din_s};
              bit_cnt_r <= bit_cnt_r + 5'h01;
              if (bit_cnt_r[2:0] == 3'h7) begin
                // Most significant byte arrives first.
                wr_en_r   <= 1'b1;
                wr_byte_r <= {shift_r[6:0], din_s};
                wr_lane_r <= 2'((nbits_r - bit_cnt_r - 5'h01) >> 3);
              end
              if (bit_cnt_r == nbits_r - 5'h01) begin
                bit_cnt_r <= 5'h00;
                state_r   <= mrbl_pkg::ST_CMD;
              end
            end
          end
          default: begin
            state_r <= mrbl_pkg::ST_CMD;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte write decode. Lanes above a register's width fall off the
  // top, so unused high bits of the first byte are ignored.
  logic [23:0] wr_mask; // Bits touched by this byte.
  logic [23:0] wr_data; // The byte copied into every lane.
  assign wr_mask = wr_en_r ? (24'h0000FF << {wr_lane_r, 3'h0}) : 24'h000000;
  assign wr_data = {3{wr_byte_r}};

  logic wr_mode, wr_mask_reg, wr_cur, wr_volt, wr_gain;
  assign wr_mode     = addr_r == mrbl_pkg::ADDR_MODE;
  assign wr_mask_reg = addr_r == mrbl_pkg::ADDR_IRQ_MASK;
  assign wr_cur      = addr_r == mrbl_pkg::ADDR_CUR_OFS;
  assign wr_volt     = addr_r == mrbl_pkg::ADDR_VOLT_OFS;
  assign wr_gain     = addr_r == mrbl_pkg::ADDR_GAIN;

  // Writable registers. Only these five addresses decode a write, so
  // read-only storage is never written by the serial port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r     <= mrbl_pkg::MODE_RST;
      mask_r     <= mrbl_pkg::IRQ_MASK_RST;
      cur_ofs_r  <= mrbl_pkg::BYTE_RST;
      volt_ofs_r <= mrbl_pkg::BYTE_RST;
      gain_r     <= mrbl_pkg::BYTE_RST;
    end else begin
      if (wr_mode) begin
        mode_r <= (mode_r & ~wr_mask[15:0])
                  | (wr_data[15:0] & wr_mask[15:0]);
      end
      if (wr_mask_reg) begin
        mask_r <= (mask_r & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0]);
      end
      if (wr_cur && wr_mask[0]) begin
        cur_ofs_r <= wr_byte_r & 8'hBF;
      end
      if (wr_volt && wr_mask[0]) begin
        volt_ofs_r <= wr_byte_r & 8'h3F;
      end
      if (wr_gain && wr_mask[0]) begin
        gain_r <= wr_byte_r;
      end
    end
  end

  assign mode           = mode_r;
  assign integrator_en  = cur_ofs_r[mrbl_pkg::INTEG_BIT];
  assign current_offset = cur_ofs_r[mrbl_pkg::OFS_MSB:0];
  assign voltage_offset = volt_ofs_r[mrbl_pkg::OFS_MSB:0];
  assign gain           = gain_r;

  ////////////////////////////////////////////////////////////////////////
  // Waveform capture. The voltage sample is 16 bits and is sign
  // extended; the others fill all 24 bits.
  logic [1:0] wsrc; // Selected source.
  assign wsrc = mode_r[mrbl_pkg::WSRC_HI:mrbl_pkg::WSRC_LO];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_r <= mrbl_pkg::ENERGY_RST;
    end else if (wsrc == mrbl_pkg::WSRC_CH1 && wave_valid) begin
      wave_r <= wave.ch1;
    end else if (wsrc == mrbl_pkg::WSRC_CH2 && wave_valid) begin
      wave_r <= {{8{wave.ch2[15]}}, wave.ch2};
    end else if (!wsrc[1] && power_valid) begin
      wave_r <= power.active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Free-running energy. A completed read of a read-clear copy zeroes
  // it, but a power sample in that same cycle is kept, not lost.
  logic clr_ae, clr_va, clr_flags;
  assign clr_ae    = rd_done_r && addr_r == mrbl_pkg::ADDR_AE_RCLR;
  assign clr_va    = rd_done_r && addr_r == mrbl_pkg::ADDR_VA_RCLR;
  assign clr_flags = rd_done_r && addr_r == mrbl_pkg::ADDR_FLAGS_RC;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ae_r    <= mrbl_pkg::ENERGY_RST;
      ae_rc_r <= mrbl_pkg::ENERGY_RST;
      va_r    <= mrbl_pkg::ENERGY_RST;
      va_rc_r <= mrbl_pkg::ENERGY_RST;
    end else begin
      if (power_valid) begin
        ae_r <= ae_r + power.active;
        va_r <= va_r + power.apparent;
      end
      ae_rc_r <= (clr_ae ? 24'h000000 : ae_rc_r)
                 + (power_valid ? power.active : 24'h000000);
      va_rc_r <= (clr_va ? 24'h000000 : va_rc_r)
                 + (power_valid ? power.apparent : 24'h000000);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line-cycle energy. After the set count of half cycles the sums are
  // latched and restart; a zero setting latches every half cycle.
  logic        line_end;   // This half cycle closes the window.
  logic [23:0] line_in [3]; // Power terms in struct order.
  assign line_end   = half_cycle &&
                      (hc_cnt_r + 15'h0001 >= half_cycle_count_setting);
  assign line_in[0] = power.active;
  assign line_in[1] = power.apparent;
  assign line_in[2] = power.reactive;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hc_cnt_r <= 15'h0000;
    end else if (line_end) begin
      hc_cnt_r <= 15'h0000;
    end else if (half_cycle) begin
      hc_cnt_r <= hc_cnt_r + 15'h0001;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_line
    logic [23:0] sum; // Running sum including this cycle's sample.
    assign sum = line_acc_r[g] + (power_valid ? line_in[g] : 24'h000000);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        line_acc_r[g] <= mrbl_pkg::ENERGY_RST;
        line_r[g]     <= mrbl_pkg::ENERGY_RST;
      end else if (line_end) begin
        line_acc_r[g] <= 24'h000000;
        line_r[g]     <= sum;
      end else begin
        line_acc_r[g] <= sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags. Events always set their flag, whatever the mask;
  // the read-clear copy clears them, and a new event wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= mrbl_pkg::FLAGS_RST;
    end else begin
      flags_r <= (clr_flags ? 16'h0000 : flags_r) | events;
    end
  end

  // Open-drain request: the pin is pulled low only while an enabled
  // flag stands.
  assign irq_n_o  = 1'b0;
  assign irq_n_oe = |(flags_r & mask_r);

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_read_done(logic [4:0] a);
    rd_done_r && addr_r == a;
  endsequence

  sequence s_no_write;
    !wr_en_r;
  endsequence

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (flags_r & mask_r) == 16'h0000 |-> !irq_n_oe)
    else $error("interrupt driven with no enabled flag");

  a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
    (events & mask_r) != 16'h0000 && !wr_en_r |=> irq_n_oe)
    else $error("enabled event left the request idle");

  a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    events != 16'h0000 |=> (flags_r & $past(events)) == $past(events))
    else $error("event did not set its flag");

  a_flags_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_done(mrbl_pkg::ADDR_FLAGS_RC) ##0 events == 16'h0000
    |=> flags_r == 16'h0000)
    else $error("flags not cleared after read-clear");

  a_ae_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_done(mrbl_pkg::ADDR_AE_RCLR) ##0 !power_valid
    |=> ae_rc_r == 24'h000000)
    else $error("active read-clear copy not zeroed");

  a_va_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_done(mrbl_pkg::ADDR_VA_RCLR) ##0 !power_valid
    |=> va_rc_r == 24'h000000)
    else $error("apparent read-clear copy not zeroed");

  a_ae_integrate: assert property (@(posedge clk) disable iff (!rst_n)
    power_valid |=> ae_r == 24'($past(ae_r) + $past(power.active)))
    else $error("active energy did not integrate");

  a_mode_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_no_write ##1 s_no_write |-> $stable(mode_r))
    else $error("mode changed without a write");

  a_ro_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en_r && !power_valid && events == 16'h0000
    |=> $stable(ae_r) && $stable(ae_rc_r) && $stable(va_r)
        && $stable(va_rc_r) && $stable(flags_r))
    else $error("write changed a read-only register");

  a_read_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == mrbl_pkg::ST_RD && !sclk_rise && !cs_idle
    |=> $stable(shift_r))
    else $error("read snapshot changed between shifts");

endmodule : mrbl_bank

/* mrbl_host.sv */
// Serial host model that drives the command port of the register bank.
// Assumes clk is the bank clock; sclk idles high and stands still
// between frames, and the data line has no pull, so a released line
// reads as the inverse of the last level seen.
`timescale 1ns/1ns
module mrbl_host (
  input  wire logic clk,
  input  wire logic dout_o,
  input  wire logic dout_oe,
  output logic      sclk,
  output logic      din,
  output logic      cs_n
);
  logic last_r; // Last level seen on the data line.

  ////////////////////////////////////////////////////////////////////////
  // One frame: command byte, then data; nbits below the full length
  // raises chip select early and so aborts the transfer.
  task automatic xfer(input logic [7:0] cmd, input int nbytes,
                      input logic [23:0] wdata, input int nbits,
                      output logic [23:0] rdata);
    logic [31:0] frame;
    logic        bit_v;
    int          total;
    frame = {cmd, wdata << (8 * (3 - nbytes))};
    total = (nbits < 8 + 8 * nbytes) ? nbits : 8 + 8 * nbytes;
    rdata = 24'h000000;
    @(posedge clk) cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < total; i++) begin
      // Write bytes need 4 us between their ends, hence the gap.
      if (cmd[7] && i >= 16 && i % 8 == 0) repeat (40) @(posedge clk);
      @(posedge clk) sclk <= 1'b1;
      repeat (2) @(posedge clk);
      din <= frame[31 - i];
      repeat (3) @(posedge clk);
      bit_v = dout_oe ? dout_o : ~last_r;
      last_r = bit_v;
      if (i >= 8) rdata = {rdata[22:0], bit_v};
      sclk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    sclk <= 1'b1;
    // A read must not follow a write within 4 us.
    repeat (cmd[7] ? 110 : 5) @(posedge clk);
  endtask : xfer

  initial begin
    sclk = 1'b1;
    din = 1'b1;
    cs_n = 1'b1;
    last_r = 1'b0;
  end
endmodule : mrbl_host

/* mrbl_bank_tb_top.sv */
// Self-checking bench for the low register bank, driven over its port.
// Assumes mrbl_host sits on the serial pins; the interrupt line has a
// pull-up, so it reads high whenever the bank does not pull it low.
`timescale 1ns/1ns
module mrbl_bank_tb_top;
  logic                  clk, rst_n, sclk, din, cs_n, dout_o, dout_oe;
  logic                  irq_n_o, irq_n_oe, power_valid, wave_valid;
  logic                  half_cycle, integrator_en;
  mrbl_pkg::mrbl_power_s power;
  mrbl_pkg::mrbl_wave_s  wave;
  logic [14:0]           hc_set;
  logic [15:0]           events, mode;
  logic [5:0]            cur_ofs, volt_ofs;
  logic [7:0]            gain;
  logic [23:0]           v;
  logic [1:0]            src;
  int                    errors, checked;
  wire                   irq_line = irq_n_oe ? irq_n_o : 1'b1; // Pull-up.

  mrbl_bank i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .din(din),
    .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .power(power), .power_valid(power_valid),
    .wave(wave), .wave_valid(wave_valid), .half_cycle(half_cycle),
    .half_cycle_count_setting(hc_set), .events(events), .mode(mode),
    .integrator_en(integrator_en), .current_offset(cur_ofs),
    .voltage_offset(volt_ofs), .gain(gain));
  mrbl_host i_host (.clk(clk), .dout_o(dout_o), .dout_oe(dout_oe),
    .sclk(sclk), .din(din), .cs_n(cs_n));

  ////////////////////////////////////////////////////////////////////////
  // Comparison, register access and pulse tasks.
  task automatic chk(input string name, input logic [23:0] e,
                     input logic [23:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input int n, input logic [23:0] e);
    logic [23:0] r;
    i_host.xfer({3'h0, a}, n, 24'h000000, 32, r);
    chk($sformatf("reg %h", a), e, r);
  endtask : rd
  task automatic wr(input logic [4:0] a, input int n, input logic [23:0] d);
    logic [23:0] r;
    i_host.xfer({3'h4, a}, n, d, 32, r);
  endtask : wr
  task automatic pw(input logic [23:0] a, input logic [23:0] b);
    @(posedge clk) power <= {a, b, 24'h000003};
    power_valid <= 1'b1;
    @(posedge clk) power_valid <= 1'b0;
  endtask : pw
  task automatic ev(input logic [15:0] e);
    @(posedge clk) events <= e;
    @(posedge clk) events <= 16'h0000;
    repeat (2) @(negedge clk);
  endtask : ev
  task automatic hc();
    @(posedge clk) half_cycle <= 1'b1;
    @(posedge clk) half_cycle <= 1'b0;
  endtask : hc
  task automatic test_done();
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and the test sequence.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    {power_valid, wave_valid, half_cycle} = 3'h0;
    power = '0;
    wave = '0;
    events = 16'h0000;
    hc_set = 15'h0002;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values through the port: mode 000Ch, mask 0040h, rest 0.
    for (int a = 1; a < 16; a++)
      rd(a[4:0], a < 9 ? 3 : (a < 13 ? 2 : 1),
         a == 9 ? 24'h00000C : (a == 10 ? 24'h000040 : 24'h0));
    chk("mode", 24'h00000C, {8'h00, mode});
    // A masked event flags but leaves the line high.
    ev(16'h0001);
    chk("irq", 24'h000001, {23'h0, irq_line});
    rd(5'h0B, 2, 24'h000001);
    ev(16'h0040);
    chk("irq", 24'h000000, {23'h0, irq_line});
    wr(5'h0B, 2, 24'h000000);
    rd(5'h0C, 2, 24'h000041);
    rd(5'h0B, 2, 24'h000000);
    chk("irq", 24'h000001, {23'h0, irq_line});
    // Energy accumulation, read-clear copies and read-only guard.
    pw(24'h100001, 24'h000200);
    pw(24'h100001, 24'h000200);
    rd(5'h02, 3, 24'h200002);
    wr(5'h02, 3, 24'hFFFFFF);
    rd(5'h03, 3, 24'h200002);
    rd(5'h03, 3, 24'h000000);
    rd(5'h02, 3, 24'h200002);
    rd(5'h05, 3, 24'h000400);
    rd(5'h06, 3, 24'h000400);
    rd(5'h06, 3, 24'h000000);
    // A power update in mid-read must not reach the bytes on the line.
    fork
      rd(5'h02, 3, 24'h200002);
      begin
        repeat (150) @(posedge clk);
        pw(24'h100001, 24'h000200);
      end
    join
    rd(5'h02, 3, 24'h300003);
    // Waveform source for settings 2, 3 and 0 of mode bits 14:13.
    for (int s = 0; s < 3; s++) begin
      src = (s == 0) ? 2'h2 : ((s == 1) ? 2'h3 : 2'h0);
      wr(5'h09, 2, {8'h00, 1'b0, src, 13'h0005});
      chk("mode", {8'h00, 1'b0, src, 13'h0005}, {8'h00, mode});
      rd(5'h09, 2, {8'h00, 1'b0, src, 13'h0005});
      @(posedge clk) wave <= {24'h812345, 16'h9ABC};
      wave_valid <= 1'b1;
      @(posedge clk) wave_valid <= 1'b0;
      pw(24'h00ABCD, 24'h000000);
      rd(5'h01, 3, s == 0 ? 24'h812345 :
         (s == 1 ? 24'hFF9ABC : 24'h00ABCD));
    end
    // Offsets, integrator enable and gain.
    wr(5'h0D, 1, 24'h0000FF);
    rd(5'h0D, 1, 24'h0000BF);
    chk("ofs", 24'h00003F, {18'h0, cur_ofs});
    chk("integ", 24'h000001, {23'h0, integrator_en});
    wr(5'h0D, 1, 24'h000040);
    chk("integ", 24'h000000, {23'h0, integrator_en});
    chk("ofs", 24'h000000, {18'h0, cur_ofs});
    wr(5'h0E, 1, 24'h0000FF);
    rd(5'h0E, 1, 24'h00003F);
    chk("vofs", 24'h00003F, {18'h0, volt_ofs});
    wr(5'h0F, 1, 24'h0000A5);
    rd(5'h0F, 1, 24'h0000A5);
    chk("gain", 24'h0000A5, {16'h0, gain});
    i_host.xfer(8'h8F, 1, 24'h00005A, 12, v);
    rd(5'h0F, 1, 24'h0000A5);
    wr(5'h10, 1, 24'h0000FF);
    rd(5'h10, 1, 24'h000000);
    // Line windows of two half cycles.
    hc();
    hc();
    pw(24'h000011, 24'h000022);
    hc();
    pw(24'h000011, 24'h000022);
    pw(24'h000011, 24'h000022);
    hc();
    rd(5'h04, 3, 24'h000033);
    rd(5'h07, 3, 24'h000066);
    rd(5'h08, 3, 24'h000009);
    // A window of three half cycles must not close after two.
    @(posedge clk) hc_set <= 15'h0003;
    pw(24'h000011, 24'h000022);
    hc();
    hc();
    pw(24'h000011, 24'h000022);
    hc();
    rd(5'h04, 3, 24'h000022);
    rd(5'h07, 3, 24'h000044);
    test_done();
  end
endmodule : mrbl_bank_tb_top
